//--- src/spu_top.sv
`default_nettype none
module spu_top (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [15:0] BAUD_DIV,
	input wire logic SYNC_MODE,
	input wire logic PARITY_EN,
	input wire logic PARITY_ODD,
	input wire logic TX_ENABLE,
	input wire logic RX_ENABLE,
	input wire logic TX_EMPTY_IRQ_EN,
	input wire logic TX_END_IRQ_EN,
	input wire logic RX_IRQ_EN,
	input wire logic PORT_DIRECTION,
	input wire logic PORT_LEVEL,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_WRITE,
	output logic TX_READY,
	input wire logic RX_READ,
	output logic [7:0] RX_DATA,
	input wire logic CLR_OVERRUN,
	input wire logic CLR_FRAMING,
	input wire logic CLR_PARITY,
	output logic TX_EMPTY_FLAG,
	output logic TX_END_FLAG,
	output logic RX_FULL_FLAG,
	output logic OVERRUN_FLAG,
	output logic FRAMING_ERR_FLAG,
	output logic PARITY_ERR_FLAG,
	output logic RX_FULL_IRQ,
	output logic TX_EMPTY_IRQ,
	output logic TX_END_IRQ,
	output logic RX_ERROR_IRQ,
	input wire logic RXD_IN,
	output logic TXD_OUT,
	output logic TXD_OE
);
	spu_fifo_if tq();
	logic rxd_s1_q, rxd_s2_q;
	logic [15:0] div_q, div_d;
	logic tick;
	spu_pkg::spu_tx_t tx_st_q, tx_st_d;
	logic [3:0] tx_ph_q, tx_ph_d;
	logic [3:0] tx_bit_q, tx_bit_d;
	logic [8:0] tx_sh_q, tx_sh_d;
	logic tx_end_q, tx_end_d;
	logic txd_q, txd_d;
	logic err_any, tx_go;
	spu_pkg::spu_rx_t rx_st_q, rx_st_d;
	logic [3:0] rx_ph_q, rx_ph_d;
	logic [3:0] rx_bit_q, rx_bit_d;
	logic [8:0] rx_sh_q, rx_sh_d;
	logic rx_prev_q, rx_prev_d;
	logic [7:0] rdr_q, rdr_d;
	logic rx_full_flag_q, rx_full_flag_d, oer_q, oer_d, fer_q, fer_d, per_q, per_d;
	logic [3:0] nbits;
	logic rx_done, rx_perr, rx_ferr;

	// Pin input resynchronised before the receiver sees it
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end
		else
		begin
			rxd_s1_q <= RXD_IN;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// Basic clock at sixteen times the bit rate
	always_comb
	begin
		tick = (div_q == '0);
		div_d = tick ? BAUD_DIV : div_q - 16'h0001;
	end

	assign tq.in_valid = TX_WRITE;
	assign tq.in_data = TX_DATA;
	assign TX_READY = tq.in_ready;
	spu_fifo #(.WIDTH(spu_pkg::DATA_W), .DEPTH(spu_pkg::FIFO_DEPTH)) u_txq (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.flush(!TX_ENABLE),
		.f(tq)
	);

	assign err_any = oer_q || fer_q || per_q;
	assign nbits = PARITY_EN ? 4'h9 : 4'h8;
	// Back-pressure: a frame starts only when the transmitter is free
	assign tx_go = tq.out_valid && !(SYNC_MODE && err_any);
	assign tq.out_ready = TX_ENABLE && tick && (tx_st_q == spu_pkg::TX_IDLE) && tx_go;

	always_comb
	begin
		tx_st_d = tx_st_q;
		tx_ph_d = tx_ph_q;
		tx_bit_d = tx_bit_q;
		tx_sh_d = tx_sh_q;
		tx_end_d = tx_end_q;
		txd_d = txd_q;
		if (!TX_ENABLE)
		begin
			// Abort mid-frame; the pin falls back to port control
			tx_st_d = spu_pkg::TX_IDLE;
			tx_ph_d = '0;
			tx_bit_d = '0;
			tx_end_d = spu_pkg::RST_TX_END;
			txd_d = 1'b1;
		end
		else if (tick)
		begin
			tx_ph_d = tx_ph_q + 4'h1;
			case (tx_st_q)
				spu_pkg::TX_IDLE:
				begin
					tx_ph_d = '0;
					if (tq.out_ready)
					begin
						tx_sh_d = {^tq.out_data ^ PARITY_ODD, tq.out_data};
						tx_st_d = spu_pkg::TX_START;
						tx_end_d = 1'b0;
						txd_d = 1'b0;
					end
				end
				spu_pkg::TX_START:
					if (tx_ph_q == 4'hf)
					begin
						tx_st_d = spu_pkg::TX_DATA;
						tx_bit_d = '0;
						txd_d = tx_sh_q[0];
						tx_sh_d = {1'b1, tx_sh_q[8:1]};
					end
				spu_pkg::TX_DATA:
					if (tx_ph_q == 4'hf)
					begin
						tx_bit_d = tx_bit_q + 4'h1;
						if (tx_bit_q == nbits - 4'h1)
						begin
							tx_st_d = spu_pkg::TX_STOP;
							txd_d = 1'b1;
						end
						else
						begin
							txd_d = tx_sh_q[0];
							tx_sh_d = {1'b1, tx_sh_q[8:1]};
						end
					end
				spu_pkg::TX_STOP:
					if (tx_ph_q == 4'hf)
					begin
						tx_st_d = spu_pkg::TX_IDLE;
						tx_end_d = !tx_go;
					end
				default:
					tx_st_d = spu_pkg::TX_IDLE;
			endcase
		end
	end

	always_comb
	begin
		rx_st_d = rx_st_q;
		rx_ph_d = rx_ph_q;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_prev_d = rx_prev_q;
		rx_done = 1'b0;
		if (!RX_ENABLE)
			rx_st_d = spu_pkg::RX_IDLE;
		else if (tick)
		begin
			rx_prev_d = rxd_s2_q;
			rx_ph_d = rx_ph_q + 4'h1;
			case (rx_st_q)
				spu_pkg::RX_IDLE:
					if (rx_prev_q && !rxd_s2_q)
					begin
						// Bit timing restarts on the falling edge
						rx_st_d = spu_pkg::RX_START;
						rx_ph_d = '0;
					end
				spu_pkg::RX_START:
					if (rx_ph_q == spu_pkg::HALF_TICK)
					begin
						if (rxd_s2_q)
							rx_st_d = spu_pkg::RX_IDLE;
					end
					else if (rx_ph_q == 4'hf)
					begin
						rx_st_d = spu_pkg::RX_DATA;
						rx_bit_d = '0;
					end
				spu_pkg::RX_DATA:
					if (rx_ph_q == spu_pkg::SAMPLE_TICK)
					begin
						rx_sh_d = {rxd_s2_q, rx_sh_q[8:1]};
						rx_bit_d = rx_bit_q + 4'h1;
					end
					else if (rx_ph_q == 4'hf && rx_bit_q == nbits)
						rx_st_d = spu_pkg::RX_STOP;
				spu_pkg::RX_STOP:
					if (rx_ph_q == spu_pkg::SAMPLE_TICK)
					begin
						// A line still low re-arms the start detector, so a break keeps framing
						rx_done = 1'b1;
						rx_prev_d = 1'b1;
						rx_st_d = spu_pkg::RX_IDLE;
					end
				default:
					rx_st_d = spu_pkg::RX_IDLE;
			endcase
		end
	end

	assign rx_ferr = rx_done && !rxd_s2_q;
	always_comb
	begin
		rx_perr = 1'b0;
		if (PARITY_EN)
			rx_perr = rx_done && ((^rx_sh_q) != PARITY_ODD);
	end

	// Set beats clear; RX_ENABLE never touches the error flags
	always_comb
	begin
		rdr_d = rdr_q;
		rx_full_flag_d = rx_full_flag_q && !RX_READ;
		oer_d = oer_q && !CLR_OVERRUN;
		fer_d = fer_q && !CLR_FRAMING;
		per_d = per_q && !CLR_PARITY;
		if (rx_done)
		begin
			if (rx_full_flag_q)
				oer_d = 1'b1;
			else
			begin
				rdr_d = PARITY_EN ? rx_sh_q[7:0] : rx_sh_q[8:1];
				rx_full_flag_d = 1'b1;
			end
			if (rx_ferr)
				fer_d = 1'b1;
			if (rx_perr)
				per_d = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			div_q <= spu_pkg::DIV_RST;
			tx_st_q <= spu_pkg::TX_IDLE;
			tx_ph_q <= '0;
			tx_bit_q <= '0;
			tx_sh_q <= '1;
			tx_end_q <= spu_pkg::RST_TX_END;
			txd_q <= 1'b1;
			rx_st_q <= spu_pkg::RX_IDLE;
			rx_ph_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
			rx_prev_q <= 1'b1;
			rdr_q <= '0;
			rx_full_flag_q <= 1'b0;
			oer_q <= 1'b0;
			fer_q <= 1'b0;
			per_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			tx_st_q <= tx_st_d;
			tx_ph_q <= tx_ph_d;
			tx_bit_q <= tx_bit_d;
			tx_sh_q <= tx_sh_d;
			tx_end_q <= tx_end_d;
			txd_q <= txd_d;
			rx_st_q <= rx_st_d;
			rx_ph_q <= rx_ph_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
			rx_prev_q <= rx_prev_d;
			rdr_q <= rdr_d;
			rx_full_flag_q <= rx_full_flag_d;
			oer_q <= oer_d;
			fer_q <= fer_d;
			per_q <= per_d;
		end
	end

	// Empty means nothing queued; resets to one with the queue empty
	assign TX_EMPTY_FLAG = !tq.out_valid;
	assign TX_END_FLAG = tx_end_q;
	assign RX_FULL_FLAG = rx_full_flag_q;
	assign OVERRUN_FLAG = oer_q;
	assign FRAMING_ERR_FLAG = fer_q;
	assign PARITY_ERR_FLAG = per_q;
	assign RX_DATA = rdr_q;
	assign RX_FULL_IRQ = rx_full_flag_q && RX_IRQ_EN;
	assign RX_ERROR_IRQ = err_any && RX_IRQ_EN;
	assign TX_EMPTY_IRQ = TX_EMPTY_FLAG && TX_EMPTY_IRQ_EN;
	assign TX_END_IRQ = tx_end_q && TX_END_IRQ_EN;
	// Port mode is combinational so it applies the same cycle
	assign TXD_OUT = TX_ENABLE ? txd_q : PORT_LEVEL;
	assign TXD_OE = TX_ENABLE ? 1'b1 : PORT_DIRECTION;
endmodule
`default_nettype wire

//--- src/spu_pkg.sv
// Functional notes
// - Four requests: rx full, tx empty, tx end, rx error from overrun/framing/parity.
// - Transmit-empty flag resets to one; early enable raises request at once.
// - Transmission-end flag resets to one; early enable raises request at once.
// - A break line of all zeros sets framing error, possibly parity error.
// - Receiver keeps running in break; a cleared framing flag sets again.
// - With tx enable low, tx pin is a port driven by direction and level.
// - Clearing tx enable initializes the transmitter at once; pin reverts to port.
// - Synchronous mode: no transmission starts while any receive error flag is set.
// - Clearing rx enable leaves error flags; only their own clear removes them.
// - Asynchronous mode uses a basic clock of sixteen times the bit rate.
// - Receiver finds start bit falling edge on basic clock and resynchronizes.
// - Each bit is latched on the eighth basic clock pulse of the bit.
// - Overrun raises error request, keeps old data, leaves rx full set.
// - Receive interrupt enable gates both rx full and rx error requests.
`default_nettype none
package spu_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int OVS = 16;
	localparam logic [3:0] SAMPLE_TICK = 4'h7;
	localparam logic [3:0] HALF_TICK = 4'h7;
	localparam logic [15:0] DIV_RST = 16'h0036;
	localparam logic RST_TX_EMPTY = 1'b1;
	localparam logic RST_TX_END = 1'b1;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11,
		TX_STOP = 2'b10} spu_tx_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
		RX_STOP = 2'b10} spu_rx_t;
endpackage
`default_nettype wire

//--- src/spu_fifo_if.sv
`default_nettype none
interface spu_fifo_if;
	logic in_valid;
	logic in_ready;
	logic [spu_pkg::DATA_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [spu_pkg::DATA_W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

//--- src/spu_fifo.sv
`default_nettype none
module spu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	spu_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d;
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic [WIDTH-1:0] dout_q, dout_d;
	logic push, pop;
	assign f.in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign f.out_valid = (cnt_q != '0);
	assign f.out_data = dout_q;
	assign push = f.in_valid && f.in_ready;
	assign pop = f.out_valid && f.out_ready;
	always_comb
	begin
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		mem_d = f.in_data;
		dout_d = mem_q[rp_q];
		if (push)
			wp_d = AW'(wp_q + 1'b1);
		if (pop)
			rp_d = AW'(rp_q + 1'b1);
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
		if (cnt_d == '0 || (push && cnt_q == '0) || (pop && cnt_q == 1 && push))
			dout_d = f.in_data;
		else
			dout_d = mem_q[rp_d];
		if (flush)
		begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			dout_q <= '0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			dout_q <= dout_d;
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wp_q] <= mem_d;
	end
endmodule
`default_nettype wire

//--- tb/spu_assertions.sv
`default_nettype none
module spu_assertions (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SYNC_MODE,
	input wire logic TX_ENABLE,
	input wire logic TX_EMPTY_IRQ_EN,
	input wire logic TX_END_IRQ_EN,
	input wire logic RX_IRQ_EN,
	input wire logic PORT_DIRECTION,
	input wire logic PORT_LEVEL,
	input wire logic CLR_FRAMING,
	input wire logic [7:0] RX_DATA,
	input wire logic TX_EMPTY_FLAG,
	input wire logic TX_END_FLAG,
	input wire logic RX_FULL_FLAG,
	input wire logic OVERRUN_FLAG,
	input wire logic FRAMING_ERR_FLAG,
	input wire logic PARITY_ERR_FLAG,
	input wire logic RX_FULL_IRQ,
	input wire logic TX_EMPTY_IRQ,
	input wire logic TX_END_IRQ,
	input wire logic RX_ERROR_IRQ,
	input wire logic TXD_OUT,
	input wire logic TXD_OE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	logic rx_err;
	assign rx_err = OVERRUN_FLAG | FRAMING_ERR_FLAG | PARITY_ERR_FLAG;
	rx_full_irq_a:
	assert property (RX_FULL_IRQ == (RX_FULL_FLAG && RX_IRQ_EN)) else $error("rx full irq");
	tx_empty_irq_a:
	assert property (TX_EMPTY_IRQ == (TX_EMPTY_FLAG && TX_EMPTY_IRQ_EN)) else $error("tx empty irq");
	tx_end_irq_a:
	assert property (TX_END_IRQ == (TX_END_FLAG && TX_END_IRQ_EN)) else $error("tx end irq");
	rx_err_irq_a:
	assert property (RX_ERROR_IRQ == (rx_err && RX_IRQ_EN)) else $error("rx error irq");
	port_pin_a:
	assert property (!TX_ENABLE |-> TXD_OUT == PORT_LEVEL && TXD_OE == PORT_DIRECTION)
		else $error("pin not under port control");
	reset_flags_a:
	assert property ($rose(RST_N) |-> TX_EMPTY_FLAG && TX_END_FLAG) else $error("reset flags");
	framing_hold_a:
	assert property (FRAMING_ERR_FLAG && !CLR_FRAMING |=> FRAMING_ERR_FLAG)
		else $error("framing flag lost");
	overrun_keep_a:
	assert property ($rose(OVERRUN_FLAG) |-> RX_FULL_FLAG && $stable(RX_DATA))
		else $error("overrun changed data");
	sync_block_a:
	assert property (SYNC_MODE && TX_ENABLE && rx_err && TX_END_FLAG |=> TXD_OUT)
		else $error("sync tx started with error");
endmodule
bind spu_top spu_assertions u_chk (.REF_CLK, .RST_N, .SYNC_MODE, .TX_ENABLE, .TX_EMPTY_IRQ_EN,
	.TX_END_IRQ_EN, .RX_IRQ_EN, .PORT_DIRECTION, .PORT_LEVEL, .CLR_FRAMING, .RX_DATA,
	.TX_EMPTY_FLAG, .TX_END_FLAG, .RX_FULL_FLAG, .OVERRUN_FLAG, .FRAMING_ERR_FLAG,
	.PARITY_ERR_FLAG, .RX_FULL_IRQ, .TX_EMPTY_IRQ, .TX_END_IRQ, .RX_ERROR_IRQ, .TXD_OUT, .TXD_OE);
`default_nettype wire

//--- tb/spu_remote.sv
`default_nettype none
module spu_remote #(
	parameter int BITC = 32
) (
	input wire logic clk,
	input wire logic txd,
	input wire logic txd_oe,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [$];
	logic [7:0] d;
	logic line;
	// A released pin floats to mark through the line pull-up
	assign line = txd_oe ? txd : 1'b1;
	initial rxd = 1'b1;
	// Idle line is pulled up to mark
	task automatic send(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BITC - 1) @(posedge clk);
		end
	endtask
	task automatic brk(input int n);
		@(posedge clk);
		rxd <= 1'b0;
		repeat (n * BITC) @(posedge clk);
		rxd <= 1'b1;
	endtask
	// Samples mid-bit, LSB first; a start bit gone by mid-bit is a glitch
	initial forever
	begin
		@(negedge line);
		repeat (BITC / 2) @(posedge clk);
		if (!line)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (BITC) @(posedge clk);
				d[i] = line;
			end
			got.push_back(d);
			repeat (BITC) @(posedge clk);
		end
	end
endmodule
`default_nettype wire

//--- tb/spu_top_tb_top.sv
`default_nettype none
module spu_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BITC = 32;
	logic REF_CLK = 1'b0, RST_N = 1'b0, SYNC_MODE = 1'b0, PARITY_EN = 1'b0, PARITY_ODD = 1'b0;
	logic TX_ENABLE = 1'b0, RX_ENABLE = 1'b0, TX_EMPTY_IRQ_EN = 1'b0, TX_END_IRQ_EN = 1'b0;
	logic RX_IRQ_EN = 1'b0, PORT_DIRECTION = 1'b0, PORT_LEVEL = 1'b0, TX_WRITE = 1'b0;
	logic RX_READ = 1'b0, CLR_OVERRUN = 1'b0, CLR_FRAMING = 1'b0, CLR_PARITY = 1'b0;
	logic [15:0] BAUD_DIV = 16'h0001;
	logic [7:0] TX_DATA = 8'h00;
	logic [7:0] RX_DATA;
	logic TX_READY, TX_EMPTY_FLAG, TX_END_FLAG, RX_FULL_FLAG, OVERRUN_FLAG, FRAMING_ERR_FLAG;
	logic PARITY_ERR_FLAG, RX_FULL_IRQ, TX_EMPTY_IRQ, TX_END_IRQ, RX_ERROR_IRQ;
	logic TXD_OUT, TXD_OE, RXD_IN;
	int bad_count = 0;
	int checks_done = 0;
	logic [11:0] rows [4] = '{12'h0c3, 12'h7b1, 12'h462, 12'ha13};
	always #5 REF_CLK = ~REF_CLK;
	spu_top u_dut (.REF_CLK, .RST_N, .BAUD_DIV, .SYNC_MODE, .PARITY_EN, .PARITY_ODD,
		.TX_ENABLE, .RX_ENABLE, .TX_EMPTY_IRQ_EN, .TX_END_IRQ_EN, .RX_IRQ_EN, .PORT_DIRECTION,
		.PORT_LEVEL, .TX_DATA, .TX_WRITE, .TX_READY, .RX_READ, .RX_DATA, .CLR_OVERRUN,
		.CLR_FRAMING, .CLR_PARITY, .TX_EMPTY_FLAG, .TX_END_FLAG, .RX_FULL_FLAG, .OVERRUN_FLAG,
		.FRAMING_ERR_FLAG, .PARITY_ERR_FLAG, .RX_FULL_IRQ, .TX_EMPTY_IRQ, .TX_END_IRQ,
		.RX_ERROR_IRQ, .RXD_IN, .TXD_OUT, .TXD_OE);
	spu_remote #(.BITC(BITC)) u_rem (.clk(REF_CLK), .txd(TXD_OUT), .txd_oe(TXD_OE), .rxd(RXD_IN));
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic bits(input int n);
		repeat (n * BITC) @(posedge REF_CLK);
		@(negedge REF_CLK);
	endtask
	task automatic summarize();
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge REF_CLK);
		bad_count++;
		summarize();
	end
	initial
	begin
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1'b1;
		foreach (rows[i])
		begin
			@(posedge REF_CLK);
			{TX_ENABLE, TX_EMPTY_IRQ_EN, TX_END_IRQ_EN, RX_IRQ_EN, PORT_DIRECTION,
				PORT_LEVEL} <= rows[i][11:6];
			@(negedge REF_CLK);
			chk("irq_pin", {2'h0, TX_EMPTY_IRQ, TX_END_IRQ, RX_FULL_IRQ, RX_ERROR_IRQ, TXD_OUT,
				TXD_OE}, {2'h0, rows[i][5:0]});
		end
		bits(1);
		@(posedge REF_CLK);
		TX_WRITE <= 1'b1;
		TX_DATA <= 8'ha5;
		@(posedge REF_CLK);
		TX_DATA <= 8'h3c;
		@(posedge REF_CLK);
		TX_WRITE <= 1'b0;
		TX_EMPTY_IRQ_EN <= 1'b1;
		@(negedge REF_CLK);
		chk("tx_empty", {5'h0, TX_EMPTY_FLAG, TX_EMPTY_IRQ, TX_READY}, 8'h01);
		for (int i = 0; i < 30000 && u_rem.got.size() < 2; i++) @(posedge REF_CLK);
		bits(2);
		chk("tx_b0", u_rem.got[0], 8'ha5);
		chk("tx_b1", u_rem.got[1], 8'h3c);
		chk("tx_end", {6'h0, TX_END_FLAG, TX_END_IRQ}, 8'h03);
		@(posedge REF_CLK);
		RX_ENABLE <= 1'b1;
		RX_IRQ_EN <= 1'b1;
		u_rem.send(8'h5a);
		bits(1);
		chk("rx_data", RX_DATA, 8'h5a);
		chk("rx_full", {6'h0, RX_FULL_FLAG, RX_FULL_IRQ}, 8'h03);
		u_rem.send(8'h99);
		bits(1);
		chk("overrun", {RX_DATA[5:0], OVERRUN_FLAG, RX_ERROR_IRQ}, 8'h6b);
		@(posedge REF_CLK);
		RX_IRQ_EN <= 1'b0;
		RX_ENABLE <= 1'b0;
		bits(1);
		chk("gated", {5'h0, RX_FULL_IRQ, RX_ERROR_IRQ, OVERRUN_FLAG}, 8'h01);
		@(posedge REF_CLK);
		RX_ENABLE <= 1'b1;
		RX_READ <= 1'b1;
		CLR_OVERRUN <= 1'b1;
		@(posedge REF_CLK);
		{RX_READ, CLR_OVERRUN} <= 2'b00;
		fork
			u_rem.brk(30);
			begin
				bits(14);
				chk("break", {7'h0, FRAMING_ERR_FLAG}, 8'h01);
				@(posedge REF_CLK);
				CLR_FRAMING <= 1'b1;
				@(posedge REF_CLK);
				CLR_FRAMING <= 1'b0;
			end
		join
		bits(1);
		chk("break_again", {7'h0, FRAMING_ERR_FLAG}, 8'h01);
		@(posedge REF_CLK);
		RX_ENABLE <= 1'b0;
		SYNC_MODE <= 1'b1;
		TX_WRITE <= 1'b1;
		TX_DATA <= 8'h0f;
		@(posedge REF_CLK);
		TX_WRITE <= 1'b0;
		bits(12);
		chk("sync_block", {TXD_OUT, 7'(u_rem.got.size())}, 8'h82);
		@(posedge REF_CLK);
		{RX_READ, CLR_OVERRUN, CLR_FRAMING, CLR_PARITY} <= 4'hf;
		@(posedge REF_CLK);
		{RX_READ, CLR_OVERRUN, CLR_FRAMING, CLR_PARITY} <= 4'h0;
		for (int i = 0; i < 30000 && u_rem.got.size() < 3; i++) @(posedge REF_CLK);
		chk("sync_go", u_rem.got[2], 8'h0f);
		bits(2);
		@(posedge REF_CLK);
		{RX_ENABLE, PARITY_EN} <= 2'b11;
		u_rem.send(8'h5a);
		bits(2);
		chk("parity", {6'h0, PARITY_ERR_FLAG, FRAMING_ERR_FLAG}, 8'h02);
		chk("par_data", RX_DATA, 8'h5a);
		@(posedge REF_CLK);
		SYNC_MODE <= 1'b0;
		{PORT_DIRECTION, PORT_LEVEL, TX_WRITE} <= 3'b101;
		TX_DATA <= 8'hff;
		@(posedge REF_CLK);
		TX_WRITE <= 1'b0;
		bits(3);
		@(posedge REF_CLK);
		TX_ENABLE <= 1'b0;
		@(negedge REF_CLK);
		chk("abort", {5'h0, TXD_OUT, TXD_OE, TX_EMPTY_FLAG}, 8'h03);
		@(negedge REF_CLK);
		chk("tx_init", {7'h0, TX_END_FLAG}, 8'h01);
		bits(12);
		summarize();
	end
endmodule
`default_nettype wire
